//--- hdl/fls_pkg.sv
// Shared constants for the flash LED fault and sync controller.
// Assumes a 100 MHz system clock; cycle counts derive from it.
package fls_pkg;
  localparam int unsigned CLK_MHZ = 100;

  // Register byte addresses
  localparam logic [7:0] ADDR_TORCH  = 8'hA0;
  localparam logic [7:0] ADDR_FLASH  = 8'hB0;
  localparam logic [7:0] ADDR_DUR    = 8'hC0;
  localparam logic [7:0] ADDR_FLAGS  = 8'hD0;
  localparam logic [7:0] ADDR_CFG1   = 8'hE0;
  localparam logic [7:0] ADDR_CFG2   = 8'hF0;
  localparam logic [7:0] ADDR_GPIO   = 8'h20;
  localparam logic [7:0] ADDR_VINMON = 8'h80;

  // Reset values
  localparam logic [7:0] RST_TORCH  = 8'h50;
  localparam logic [7:0] RST_FLASH  = 8'h68;
  localparam logic [7:0] RST_DUR    = 8'h4F;
  localparam logic [7:0] RST_FLAGS  = 8'h40;
  localparam logic [7:0] RST_CFG1   = 8'h42;
  localparam logic [7:0] RST_CFG2   = 8'hF0;
  localparam logic [7:0] RST_GPIO   = 8'h80;
  localparam logic [7:0] RST_VINMON = 8'hF0;

  // Field positions
  localparam int FLASH_STR_BIT  = 7;
  localparam int CFG1_HWTORCH   = 7;
  localparam int CFG1_TX2_POL   = 6;
  localparam int CFG1_TX2_MODE  = 5;
  localparam int CFG1_NTC_MODE  = 3;
  localparam int CFG2_TX2_OFF   = 0;
  localparam int CFG2_NTC_OFF   = 1;
  localparam int CFG2_AET       = 2;
  localparam int CFG2_VIN_OFF   = 3;
  localparam int GPIO_G2_MODE   = 3;
  localparam int GPIO_G2_DIR    = 4;
  localparam int GPIO_G2_DATA   = 5;
  localparam int GPIO_G2_NTCOUT = 6;
  localparam int VINMON_EN      = 0;
  localparam int FLG_TIMEOUT    = 0;
  localparam int FLG_OVERTEMP   = 1;
  localparam int FLG_LEDFAULT   = 2;
  localparam int FLG_TX1        = 3;
  localparam int FLG_TX2        = 4;
  localparam int FLG_NTC        = 5;
  localparam int FLG_VIN        = 6;

  // Enable field codes, bits [1:0] of torch and flash registers
  localparam logic [1:0] EN_OFF   = 2'h0;
  localparam logic [1:0] EN_IND   = 2'h1;
  localparam logic [1:0] EN_TORCH = 2'h2;
  localparam logic [1:0] EN_FLASH = 2'h3;

  // Timing
  localparam int unsigned NTC_DEGLITCH_US = 250;
  localparam int unsigned SHORT_DELAY_US  = 250;
  localparam int unsigned OPEN_DELAY_US   = 2;
  localparam int unsigned RAMP_STEP_US    = 16;
  localparam int unsigned TIMEOUT_STEP_MS = 32;
  localparam int unsigned NTC_DEGLITCH_CYC = NTC_DEGLITCH_US * CLK_MHZ;
  localparam int unsigned SHORT_DELAY_CYC  = SHORT_DELAY_US * CLK_MHZ;
  localparam int unsigned OPEN_DELAY_CYC   = OPEN_DELAY_US * CLK_MHZ;
  localparam int unsigned RAMP_STEP_CYC    = RAMP_STEP_US * CLK_MHZ;
  localparam int unsigned MS_CYC           = 1000 * CLK_MHZ;

  typedef enum logic [1:0] {
    FLS_IDLE  = 2'b00,
    FLS_TORCH = 2'b01,
    FLS_FLASH = 2'b11,
    FLS_AET   = 2'b10
  } fls_state_t;
endpackage

//--- hdl/fls_sync.sv
// Three-stage synchroniser for asynchronous pins and comparator levels.
// Assumes inputs may change at any time relative to clk_i.
`timescale 1ns/1ps
`default_nettype none
module fls_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } fls_sync_st_t;

  fls_sync_st_t q;
  fls_sync_st_t n;

  always_comb begin
    n = q;
    n.s1 = d_i;
    n.s2 = q.s1;
    n.s3 = q.s2;
    // Accept a level only once stages two and three agree
    n.val = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.val);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign q_o = q.val;
endmodule
`default_nettype wire

//--- hdl/fls_ctrl.sv
// Flash LED control: mode sequencing, sync inputs, fault flags, pin mux.
// Assumes a serial-bus engine issues one-cycle register strobes and
// that pins and comparator levels arrive asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module fls_ctrl #(
  parameter int unsigned NTC_DEGLITCH_CYC = fls_pkg::NTC_DEGLITCH_CYC,
  parameter int unsigned SHORT_DELAY_CYC  = fls_pkg::SHORT_DELAY_CYC,
  parameter int unsigned MS_CYC           = fls_pkg::MS_CYC
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // Register access from the serial-bus engine
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Pins
  input  wire logic       hardware_enable_input_i,
  input  wire logic       strobe_i,
  input  wire logic       first_sync_input_i,
  input  wire logic       mf_pin_i,
  output logic            mf_pin_o,
  output logic            mf_pin_oe_n_o,
  // Analog comparators
  input  wire logic       thermistor_sense_i,
  input  wire logic       vin_low_i,
  input  wire logic       vin_recovered_i,
  input  wire logic       overtemp_i,
  input  wire logic       ovp_i,
  input  wire logic       short_a_i,
  input  wire logic       short_b_i,
  // Power stage control
  output logic            converter_on_o,
  output logic            voltage_mode_o,
  output logic            flash_sources_on_o,
  output logic            torch_scale_o,
  output logic      [3:0] led_level_o,
  output logic            indicator_on_o,
  output logic      [1:0] indicator_level_o,
  output logic            vin_monitor_en_o,
  output logic      [1:0] vin_threshold_sel_o
);
  localparam int DGW = $clog2(NTC_DEGLITCH_CYC + 1);
  localparam int SHW = $clog2(SHORT_DELAY_CYC + 1);
  localparam int MSW = $clog2(MS_CYC + 1);
  localparam int RPW = $clog2(fls_pkg::RAMP_STEP_CYC + 1);
  localparam int OPW = $clog2(fls_pkg::OPEN_DELAY_CYC + 1);

  typedef struct packed {
    logic [7:0] torch, flash, dur, cfg1, cfg2, gpio, vinmon, flags;
    fls_pkg::fls_state_t st;
    logic           str_flash;
    logic [MSW-1:0] ms_cnt;
    logic [10:0]    tmo_cnt;
    logic [RPW-1:0] ramp_cnt;
    logic [3:0]     level;
    logic           tbl;
    logic [DGW-1:0] ntc_cnt;
    logic [SHW-1:0] short_cnt;
    logic [OPW-1:0] open_cnt;
    logic           ntc_hold, ntc_seen, vin_hold, vin_seen, tx2_off;
    logic           strobe_p, tx1_p, tx2_p, ovt_p;
    logic [7:0]     rdata;
    logic           mf_o, mf_oe_n, conv, vmode, src_on, ind_on;
  } fls_st_t;

  fls_st_t q;
  fls_st_t n;

  logic [10:0] pin;
  logic hardware_enable_input, strobe, tx1, mf, ntc_in, vlow, vrec, overtemp_flag, ovp, shrt;
  logic rd_flags, tx1_mode, tx2_mode, tx2_act, ntc_mode, active;
  logic req_flash, req_torch, strobe_rise, tmo_hit, ntc_ok;
  logic kill, to_torch, n_tbl;
  logic [3:0] target;
  logic [7:0] sets;
  logic [10:0] limit;

  fls_sync #(
    .W (11)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({short_b_i, short_a_i, ovp_i, overtemp_i, vin_recovered_i, vin_low_i,
                thermistor_sense_i, mf_pin_i, first_sync_input_i, strobe_i,
                hardware_enable_input_i}),
    .q_o      (pin)
  );

  always_comb begin
    n = q;
    {shrt, ovp, overtemp_flag, vrec, vlow, ntc_in, mf, tx1, strobe, hardware_enable_input} =
      {pin[10] | pin[9], pin[8:0]};
    rd_flags = reg_rd_i && (reg_addr_i == fls_pkg::ADDR_FLAGS);
    tx1_mode = !q.cfg1[fls_pkg::CFG1_HWTORCH];
    tx2_mode = q.cfg1[fls_pkg::CFG1_TX2_MODE] && !q.gpio[fls_pkg::GPIO_G2_MODE];
    tx2_act  = tx2_mode && (q.cfg1[fls_pkg::CFG1_TX2_POL] ? mf : !mf);
    ntc_mode = q.cfg1[fls_pkg::CFG1_NTC_MODE];
    active   = (q.st != fls_pkg::FLS_IDLE);
    req_flash = (q.torch[1:0] == fls_pkg::EN_FLASH) || (q.flash[1:0] == fls_pkg::EN_FLASH);
    req_torch = (q.torch[1:0] == fls_pkg::EN_TORCH) || (q.flash[1:0] == fls_pkg::EN_TORCH) ||
                (!tx1_mode && tx1);
    strobe_rise = strobe && !q.strobe_p;
    limit   = {1'b0, 5'(q.dur[4:0] + 5'h1), 5'h00} | {(q.dur[4:0] == 5'h1F), 10'h000};
    tmo_hit = (q.tmo_cnt == limit);
    ntc_ok  = (q.ntc_cnt == DGW'(NTC_DEGLITCH_CYC));

    // Persistence counters for thermistor trip and LED faults
    n.ntc_cnt = (ntc_mode && ntc_in) ? (ntc_ok ? q.ntc_cnt : q.ntc_cnt + DGW'(1)) : '0;
    n.short_cnt = (active && shrt) ? ((q.short_cnt == SHW'(SHORT_DELAY_CYC)) ? q.short_cnt
                  : q.short_cnt + SHW'(1)) : '0;
    n.open_cnt = (active && ovp) ? ((q.open_cnt == OPW'(fls_pkg::OPEN_DELAY_CYC)) ? q.open_cnt
                 : q.open_cnt + OPW'(1)) : '0;

    sets = '0;
    sets[fls_pkg::FLG_OVERTEMP] = overtemp_flag && !q.ovt_p;
    sets[fls_pkg::FLG_LEDFAULT] = active && ((q.open_cnt == OPW'(fls_pkg::OPEN_DELAY_CYC)) ||
                                  (q.short_cnt == SHW'(SHORT_DELAY_CYC)));
    sets[fls_pkg::FLG_TX1] = tx1_mode && tx1 && !q.tx1_p;
    sets[fls_pkg::FLG_TX2] = tx2_act && !q.tx2_p;
    sets[fls_pkg::FLG_NTC] = ntc_mode && active && ntc_ok;
    sets[fls_pkg::FLG_VIN] = q.vinmon[fls_pkg::VINMON_EN] && vlow;
    sets[fls_pkg::FLG_TIMEOUT] = (q.st == fls_pkg::FLS_FLASH) && tmo_hit;

    // Holds that keep current reduced until software has read the flags and, for thermistor and input voltage, the fault has cleared
    n.ntc_seen = (q.ntc_seen || (rd_flags && q.ntc_hold)) && q.ntc_hold;
    n.ntc_hold = sets[fls_pkg::FLG_NTC] || (q.ntc_hold && !(q.ntc_seen && !ntc_in));
    n.vin_seen = (q.vin_seen || (rd_flags && q.vin_hold)) && q.vin_hold;
    n.vin_hold = sets[fls_pkg::FLG_VIN] || (q.vin_hold && !(q.vin_seen && vrec));
    n.tx2_off = (tx2_act && (q.st == fls_pkg::FLS_FLASH) && q.cfg2[fls_pkg::CFG2_TX2_OFF]) ||
                (q.tx2_off && !rd_flags);

    // Register writes; flags are read-only
    if (reg_wr_i) begin
      if (reg_addr_i == fls_pkg::ADDR_TORCH) begin
        n.torch = reg_wdata_i;
      end else if (reg_addr_i == fls_pkg::ADDR_FLASH) begin
        n.flash = reg_wdata_i;
      end else if (reg_addr_i == fls_pkg::ADDR_DUR) begin
        n.dur = reg_wdata_i;
      end else if (reg_addr_i == fls_pkg::ADDR_CFG1) begin
        n.cfg1 = reg_wdata_i;
      end else if (reg_addr_i == fls_pkg::ADDR_CFG2) begin
        n.cfg2 = reg_wdata_i;
      end else if (reg_addr_i == fls_pkg::ADDR_GPIO) begin
        n.gpio = reg_wdata_i;
      end else if (reg_addr_i == fls_pkg::ADDR_VINMON) begin
        n.vinmon = reg_wdata_i;
      end
    end

    // Mode sequencing; a flash always ends with all sources off
    n.ms_cnt = (q.ms_cnt == MSW'(MS_CYC - 1)) ? '0 : q.ms_cnt + MSW'(1);
    if (q.ms_cnt == MSW'(MS_CYC - 1)) begin
      n.tmo_cnt = q.tmo_cnt + 11'h001;
    end
    case (q.st)
      fls_pkg::FLS_IDLE, fls_pkg::FLS_TORCH: begin
        n.st = req_torch ? fls_pkg::FLS_TORCH : fls_pkg::FLS_IDLE;
        if (strobe_rise || req_flash) begin
          n.st = (strobe_rise && tx1 && q.cfg2[fls_pkg::CFG2_AET]) ?
                 fls_pkg::FLS_AET : fls_pkg::FLS_FLASH;
          n.str_flash = strobe_rise;
          n.ms_cnt = '0;
          n.tmo_cnt = '0;
        end
      end
      fls_pkg::FLS_FLASH: begin
        if (tmo_hit || (q.str_flash && !q.flash[fls_pkg::FLASH_STR_BIT] && !strobe)) begin
          n.st = fls_pkg::FLS_IDLE;
          n.torch[1:0] = fls_pkg::EN_OFF;
          n.flash[1:0] = fls_pkg::EN_OFF;
          n.cfg1[fls_pkg::CFG1_HWTORCH] = 1'b0;
        end else if (!q.str_flash && !req_flash) begin
          n.st = fls_pkg::FLS_IDLE;
        end else if (strobe_rise && !q.flash[fls_pkg::FLASH_STR_BIT]) begin
          n.ms_cnt = '0;
          n.tmo_cnt = '0;
        end
      end
      default: begin
        // Untimed torch held by the strobe
        if (!strobe) begin
          n.st = fls_pkg::FLS_IDLE;
          n.flash[1:0] = fls_pkg::EN_OFF;
          n.torch[1:0] = fls_pkg::EN_OFF;
        end
      end
    endcase

    // Flags: set beats the read clear; a new flash clears timeout
    n.flags = rd_flags ? 8'h00 : q.flags;
    if ((q.st != fls_pkg::FLS_FLASH) && (n.st == fls_pkg::FLS_FLASH)) begin
      n.flags[fls_pkg::FLG_TIMEOUT] = 1'b0;
    end
    n.flags = n.flags | sets;

    if (!hardware_enable_input) begin
      n.flags = 8'h00;
      n.st = fls_pkg::FLS_IDLE;
      n.torch[1:0] = fls_pkg::EN_OFF;
      n.flash[1:0] = fls_pkg::EN_OFF;
      n.ntc_hold = 1'b0;
      n.vin_hold = 1'b0;
      n.tx2_off = 1'b0;
    end

    n.strobe_p = strobe;
    n.tx1_p = tx1;
    n.tx2_p = tx2_act;
    n.ovt_p = overtemp_flag;

    // Current-source action from the highest-priority condition
    kill = overtemp_flag || q.tx2_off || (q.ntc_hold && q.cfg2[fls_pkg::CFG2_NTC_OFF]) ||
           (q.vin_hold && q.cfg2[fls_pkg::CFG2_VIN_OFF]) ||
           ((n.st == fls_pkg::FLS_FLASH) && tx2_act && q.cfg2[fls_pkg::CFG2_TX2_OFF]);
    to_torch = (tx1_mode && tx1) || (tx2_act && !q.cfg2[fls_pkg::CFG2_TX2_OFF]) ||
               q.ntc_hold || q.vin_hold;
    n.src_on = (n.st != fls_pkg::FLS_IDLE) && !kill;
    n_tbl = (n.st != fls_pkg::FLS_FLASH) || to_torch;
    target = n_tbl ? {1'b0, q.torch[5:3]} : q.flash[6:3];
    n.tbl = n_tbl;
    if (!n.src_on) begin
      n.level = 4'h0;
      n.ramp_cnt = '0;
    end else if (n_tbl && !q.tbl) begin
      n.level = target;
    end else if (n_tbl != q.tbl) begin
      n.level = 4'h0;
      n.ramp_cnt = '0;
    end else if (q.level > target) begin
      n.level = target;
    end else if (q.level < target) begin
      if (q.ramp_cnt == RPW'(fls_pkg::RAMP_STEP_CYC - 1)) begin
        n.ramp_cnt = '0;
        n.level = q.level + 4'h1;
      end else begin
        n.ramp_cnt = q.ramp_cnt + RPW'(1);
      end
    end

    n.ind_on = !n.cfg1[fls_pkg::CFG1_NTC_MODE] && !overtemp_flag &&
               ((n.torch[1:0] == fls_pkg::EN_IND) || (n.flash[1:0] == fls_pkg::EN_IND));
    n.vmode = n.torch[2] || n.flash[2] ||
              (!n.cfg1[fls_pkg::CFG1_TX2_MODE] && !n.gpio[fls_pkg::GPIO_G2_MODE] && mf);
    n.conv = (n.vmode || n.src_on || n.ind_on) && !overtemp_flag;

    // Multi-function pin drive; open drain only pulls low
    n.mf_o = 1'b0;
    n.mf_oe_n = 1'b1;
    if (n.gpio[fls_pkg::GPIO_G2_MODE] && n.gpio[fls_pkg::GPIO_G2_DIR]) begin
      if (n.gpio[fls_pkg::GPIO_G2_NTCOUT] && n.cfg1[fls_pkg::CFG1_NTC_MODE]) begin
        n.mf_oe_n = !n.flags[fls_pkg::FLG_NTC];
      end else begin
        n.mf_o = n.gpio[fls_pkg::GPIO_G2_DATA];
        n.mf_oe_n = 1'b0;
      end
    end

    if (reg_rd_i) begin
      if (reg_addr_i == fls_pkg::ADDR_TORCH) begin
        n.rdata = q.torch;
      end else if (reg_addr_i == fls_pkg::ADDR_FLASH) begin
        n.rdata = q.flash;
      end else if (reg_addr_i == fls_pkg::ADDR_DUR) begin
        n.rdata = q.dur;
      end else if (reg_addr_i == fls_pkg::ADDR_FLAGS) begin
        n.rdata = q.flags;
      end else if (reg_addr_i == fls_pkg::ADDR_CFG1) begin
        n.rdata = q.cfg1;
      end else if (reg_addr_i == fls_pkg::ADDR_CFG2) begin
        n.rdata = q.cfg2;
      end else if (reg_addr_i == fls_pkg::ADDR_GPIO) begin
        n.rdata = {q.gpio[7:6], q.gpio[fls_pkg::GPIO_G2_DIR] ? q.gpio[5] : mf, q.gpio[4:0]};
      end else if (reg_addr_i == fls_pkg::ADDR_VINMON) begin
        n.rdata = q.vinmon;
      end else begin
        n.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.torch <= fls_pkg::RST_TORCH;
      q.flash <= fls_pkg::RST_FLASH;
      q.dur <= fls_pkg::RST_DUR;
      q.flags <= fls_pkg::RST_FLAGS;
      q.cfg1 <= fls_pkg::RST_CFG1;
      q.cfg2 <= fls_pkg::RST_CFG2;
      q.gpio <= fls_pkg::RST_GPIO;
      q.vinmon <= fls_pkg::RST_VINMON;
      q.mf_oe_n <= 1'b1;
      q.tbl <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign mf_pin_o = q.mf_o;
  assign mf_pin_oe_n_o = q.mf_oe_n;
  assign converter_on_o = q.conv;
  assign voltage_mode_o = q.vmode;
  assign flash_sources_on_o = q.src_on;
  assign torch_scale_o = q.tbl;
  assign led_level_o = q.level;
  assign indicator_on_o = q.ind_on;
  assign indicator_level_o = q.torch[7:6];
  assign vin_monitor_en_o = q.vinmon[fls_pkg::VINMON_EN];
  assign vin_threshold_sel_o = q.vinmon[2:1];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_set_wins;
    rd_flags && hardware_enable_input && (sets != 8'h00) |=> ((q.flags & $past(sets)) == $past(sets));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost under flags read");

  property p_tx2_hold;
    q.tx2_off && !rd_flags && hardware_enable_input |=> q.tx2_off ##0 !flash_sources_on_o;
  endproperty
  a_tx2_hold: assert property (p_tx2_hold)
    else $error("second sync shutdown released early");

  property p_fault_pin;
    q.flags[fls_pkg::FLG_NTC] && q.gpio[fls_pkg::GPIO_G2_MODE] && q.gpio[fls_pkg::GPIO_G2_DIR]
      && q.gpio[fls_pkg::GPIO_G2_NTCOUT] && q.cfg1[fls_pkg::CFG1_NTC_MODE]
      |-> !mf_pin_oe_n_o && !mf_pin_o;
  endproperty
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault pin not pulled low");

  property p_overtemp_off;
    overtemp_flag |=> !flash_sources_on_o && !converter_on_o && !indicator_on_o;
  endproperty
  a_overtemp_off: assert property (p_overtemp_off)
    else $error("sources on during overtemp");

  property p_ind_mode;
    indicator_on_o |-> !q.cfg1[fls_pkg::CFG1_NTC_MODE];
  endproperty
  a_ind_mode: assert property (p_ind_mode)
    else $error("indicator on in thermistor mode");

  property p_deglitch;
    $rose(q.ntc_hold) |-> $past(q.ntc_cnt) == DGW'(NTC_DEGLITCH_CYC);
  endproperty
  a_deglitch: assert property (p_deglitch)
    else $error("thermistor hold without full deglitch");

  property p_read_clears;
    rd_flags && !sets[fls_pkg::FLG_TX1] && !sets[fls_pkg::FLG_TX2]
      |=> !q.flags[fls_pkg::FLG_TX1] && !q.flags[fls_pkg::FLG_TX2];
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("sync event flags survive read");

  property p_timeout;
    (q.st == fls_pkg::FLS_FLASH) && tmo_hit && hardware_enable_input
      |=> q.flags[fls_pkg::FLG_TIMEOUT] && (q.st == fls_pkg::FLS_IDLE) ##1 !flash_sources_on_o;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout not flagged or flash not ended");
endmodule
`default_nettype wire

//--- tb/fls_host_model.sv
// Host side of the register port: one-cycle write and read strobes.
// Assumes the design samples strobes on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module fls_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register strobes
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = v;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    // Stale data must not look valid
    reg_wdata_o = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    v = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_flash_led_fault_sync_control.sv
// Self-checking bench for the flash controller, flags kept in a model.
// Assumes a 100 MHz clock and shortened deglitch and timeout counts.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_led_fault_sync_control;
  logic       clk_i, resetn_i, hardware_enable_input, mf_drv, thermistor_sense, vlow, vrec, ot, sa, zero, tx1;
  wire        wr, rd, oe_n, mf_o, mf_pin, conv, vmode, src_on, ind_on, vmon_en, tscale;
  wire  [7:0] addr, wdata, rdata;
  wire  [1:0] ind_lvl, vthr;
  wire  [3:0] level;
  int         fail_count = 0;
  int         total_checks = 0;
  int         exp_flags = 0;
  int         seed = 25546;
  int         rnd;
  logic [7:0] d, r;
  logic [7:0] ra [4];
  logic [7:0] rv [4];

  // Bench drives the shared pin from mf_drv when the design lets go
  assign mf_pin = oe_n ? mf_drv : mf_o;

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  fls_host_model u_host (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  fls_ctrl #(.NTC_DEGLITCH_CYC(20), .SHORT_DELAY_CYC(20), .MS_CYC(10)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .hardware_enable_input_i(hardware_enable_input),
    .strobe_i(zero), .first_sync_input_i(tx1), .mf_pin_i(mf_pin), .mf_pin_o(mf_o),
    .mf_pin_oe_n_o(oe_n), .thermistor_sense_i(thermistor_sense), .vin_low_i(vlow),
    .vin_recovered_i(vrec), .overtemp_i(ot), .ovp_i(zero), .short_a_i(sa),
    .short_b_i(zero), .converter_on_o(conv), .voltage_mode_o(vmode),
    .flash_sources_on_o(src_on), .torch_scale_o(tscale), .led_level_o(level),
    .indicator_on_o(ind_on), .indicator_level_o(ind_lvl), .vin_monitor_en_o(vmon_en),
    .vin_threshold_sel_o(vthr));

  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic [1:0] g, input logic [1:0] e);
    chk_reg({6'h00, g}, {6'h00, e});
  endtask
  task automatic rd_flags;
    u_host.rd(fls_pkg::ADDR_FLAGS, d);
    chk_reg(d, exp_flags[7:0]);
    exp_flags = 0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    give_verdict;
  end

  initial begin
    ra = '{fls_pkg::ADDR_TORCH, fls_pkg::ADDR_CFG1, fls_pkg::ADDR_CFG2, fls_pkg::ADDR_VINMON};
    rv = '{fls_pkg::RST_TORCH, fls_pkg::RST_CFG1, fls_pkg::RST_CFG2, fls_pkg::RST_VINMON};
    {resetn_i, mf_drv, thermistor_sense, vlow, vrec, ot, sa, zero, tx1} = 9'h000;
    hardware_enable_input = 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    resetn_i = 1'b1;
    wt(8);
    for (int i = 0; i < 4; i++) begin
      u_host.rd(ra[i], d);
      chk_reg(d, rv[i]);
    end
    u_host.rd(fls_pkg::ADDR_FLAGS, d);
    rd_flags;
    $display("test reset done");
    for (int t = 0; t < 4; t++) begin
      rnd = $random(seed);
      r = {5'h1E, t[1:0], rnd[0]};
      u_host.wr(fls_pkg::ADDR_VINMON, r);
      u_host.rd(fls_pkg::ADDR_VINMON, d);
      chk_reg(d, r);
      chk_pin({1'b0, vmon_en}, {1'b0, r[0]});
      chk_pin(vthr, r[2:1]);
    end
    u_host.wr(fls_pkg::ADDR_VINMON, 8'hF1);
    vlow = 1'b1;
    wt(8);
    exp_flags = 1 << fls_pkg::FLG_VIN;
    rd_flags;
    vlow = 1'b0;
    vrec = 1'b1;
    u_host.wr(fls_pkg::ADDR_VINMON, 8'hF0);
    wt(6);
    u_host.rd(fls_pkg::ADDR_FLAGS, d);
    $display("test vin monitor done");
    // Torch on first, so the shutdown has something to stop
    u_host.wr(fls_pkg::ADDR_TORCH, 8'h52);
    wt(4);
    chk_pin({conv, src_on}, 2'b11);
    ot = 1'b1;
    wt(8);
    chk_pin({conv, src_on}, 2'b00);
    exp_flags = 1 << fls_pkg::FLG_OVERTEMP;
    rd_flags;
    wt(4);
    rd_flags;
    ot = 1'b0;
    wt(6);
    ot = 1'b1;
    wt(8);
    hardware_enable_input = 1'b0;
    wt(8);
    ot = 1'b0;
    hardware_enable_input = 1'b1;
    wt(8);
    rd_flags;
    $display("test overtemp done");
    mf_drv = 1'b1;
    wt(6);
    chk_pin({1'b0, vmode}, 2'b01);
    mf_drv = 1'b0;
    u_host.wr(fls_pkg::ADDR_CFG1, 8'h62);
    wt(6);
    u_host.rd(fls_pkg::ADDR_FLAGS, d);
    mf_drv = 1'b1;
    wt(6);
    chk_pin({1'b0, vmode}, 2'b00);
    exp_flags = 1 << fls_pkg::FLG_TX2;
    rd_flags;
    rd_flags;
    $display("test sync pin done");
    rnd = $random(seed);
    r = {rnd[1:0], 6'h01};
    u_host.wr(fls_pkg::ADDR_TORCH, r);
    wt(2);
    chk_pin({1'b0, ind_on}, 2'b01);
    chk_pin(ind_lvl, r[7:6]);
    u_host.wr(fls_pkg::ADDR_CFG1, 8'h4A);
    wt(2);
    chk_pin({1'b0, ind_on}, 2'b00);
    $display("test indicator done");
    u_host.wr(fls_pkg::ADDR_TORCH, 8'h52);
    wt(4);
    chk_pin({1'b0, src_on}, 2'b01);
    sa = 1'b1;
    wt(40);
    // Release first: a saturated count keeps setting the flag a few cycles
    sa = 1'b0;
    wt(6);
    exp_flags = 1 << fls_pkg::FLG_LEDFAULT;
    rd_flags;
    u_host.wr(fls_pkg::ADDR_GPIO, 8'h58);
    wt(4);
    chk_pin({1'b0, mf_pin}, 2'b01);
    thermistor_sense = 1'b1;
    wt(10);
    chk_pin({1'b0, mf_pin}, 2'b01);
    wt(30);
    chk_pin({1'b0, mf_pin}, 2'b00);
    thermistor_sense = 1'b0;
    wt(8);
    chk_pin({1'b0, mf_pin}, 2'b00);
    exp_flags = 1 << fls_pkg::FLG_NTC;
    rd_flags;
    wt(4);
    chk_pin({1'b0, mf_pin}, 2'b01);
    $display("test fault pin done");
    // Shortest timeout: 32 ticks of the shortened millisecond
    u_host.wr(fls_pkg::ADDR_DUR, 8'h40);
    u_host.wr(fls_pkg::ADDR_FLASH, 8'h0B);
    wt(4);
    chk_pin({src_on, tscale}, 2'b10);
    tx1 = 1'b1;
    wt(8);
    chk_pin({src_on, tscale}, 2'b11);
    chk_reg({4'h0, level}, 8'h02);
    tx1 = 1'b0;
    wt(8);
    chk_pin({src_on, tscale}, 2'b10);
    chk_reg({4'h0, level}, 8'h00);
    wt(320);
    chk_pin({src_on, tscale}, 2'b01);
    exp_flags = (1 << fls_pkg::FLG_TX1) | (1 << fls_pkg::FLG_TIMEOUT);
    rd_flags;
    u_host.rd(fls_pkg::ADDR_FLASH, d);
    chk_reg(d, 8'h08);
    u_host.rd(fls_pkg::ADDR_TORCH, d);
    chk_reg(d, 8'h50);
    $display("test flash timeout done");
    give_verdict;
  end
endmodule
`default_nettype wire
